// File: src/mode_selector_consts.vh
`ifndef MODE_SELECTOR_CONSTS_VH
`define MODE_SELECTOR_CONSTS_VH

// clock and base tick
`define CLK_NS 5
`define TICK_NS 1000000
`define TICK_W 18

// times in ms, one tick is 1 ms
`define FILTER_MS 50
`define MSG_MS 200
`define LONG_MS 5000
`define LONG5_MS 10000
`define SERVICE_MS 3000
`define FLASH_MS 250
`define STUCK_MS 20
`define MS_TICKS(t) ((t) * (1000000 / `TICK_NS))

// configuration switch fields
`define DIP_BEH_LSB 0
`define DIP_BEH_MSB 1
`define DIP_ADV_BIT 2
`define DIP_RSV_BIT 3
`define BEH_DEFAULT 2'h0
`define BEH_RETAIN 2'h1
`define BEH_FALLBACK 2'h2
`define BEH_STORE 2'h3

// status codes
`define CODE_PRESEL 4'h0
`define CODE_SVC_TAG 4'h2
`define CODE_MODE5 4'h3
`define CODE_TAG1 4'h4
`define CODE_MODE1 4'h8
`define CODE_NO_PERM 4'hc
`define CODE_DEV_ERR 4'hd
`define CODE_BAD_BTN 4'he
`define CODE_TAG_OUT 4'hf

// modes
`define MODE_1 3'h1
`define MODE_4 3'h4
`define MODE_5 3'h5

// reset values
`define STATUS_RST 4'h8
`define MODE_RST 3'h1

`endif

// File: src/input_sync.v
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
	parameter W = 17
) (
	input wire sys_clk,
	input wire nrst,
	input wire clk_en,
	input wire [W-1:0] din,
	output wire [W-1:0] dout
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg out_q;
			always @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					out_q <= 1'b0;
				end else if (clk_en) begin
					s1_q <= din[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					// only accept a level once two settled stages agree
					if (s2_q == s3_q)
						out_q <= s3_q;
				end
			end
			assign dout[i] = out_q;
		end
	endgenerate
endmodule // input_sync
`default_nettype wire

// File: src/tick_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "mode_selector_consts.vh"
module tick_timer #(
	parameter TICK_CYCLES = `TICK_NS / `CLK_NS
) (
	input wire sys_clk,
	input wire nrst,
	input wire clk_en,
	output reg tick
);
	localparam integer LAST_I = TICK_CYCLES - 1;
	localparam [`TICK_W-1:0] LAST = LAST_I[`TICK_W-1:0];
	reg [`TICK_W-1:0] cnt_q;
	// free-running; every millisecond timing in the block counts these pulses
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= {`TICK_W{1'b0}};
			tick <= 1'b0;
		end else if (clk_en) begin
			tick <= (cnt_q == LAST); // RULE_23
			if (cnt_q == LAST)
				cnt_q <= {`TICK_W{1'b0}};
			else
				cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule // tick_timer
`default_nettype wire

// File: src/mode_selector.v
// Function
// RULE_01: at start-up only defined switch settings are accepted, others give device error
// RULE_02: retention or storage keeps the current mode when the tag is removed
// RULE_03: fallback, or service fallback from mode 5, returns to mode 1 on removal
// RULE_04: after reset under retention, fallback or service fallback, start in mode 1
// RULE_05: after reset under storage, restart in the last selected mode
// RULE_06: mode 5 flashes all four displays
// RULE_07: button 1 selects mode 1 or 5 by hold time, buttons 2-4 modes 2-4
// RULE_08: the controller checks that exactly one safe-mode output is active
// RULE_09: the controller tolerates all outputs zero at power-on and switchover
// RULE_10: status code 8h-Bh for modes 1-4, 3h for mode 5, bit 3 is msb
// RULE_11: tag arrival reports level 1-4 as 4h-7h and level 5 as 2h
// RULE_12: error codes Ch, Dh, Eh, Fh and preselection code 0h
// RULE_13: mode and device-error codes stay; others show 200 ms then mode code
// RULE_14: missing permission for absent, late or insufficient tag
// RULE_15: a press during mode lock is refused as missing permission; the code checks mode lock only in advanced config
// RULE_16: switch change, stuck safe-mode output or internal fault gives device error
// RULE_17: hold over 5 s for modes 1-4 or over 10 s for mode 5 is misuse
// RULE_18: several buttons together or release after tag removal is misuse
// RULE_19: presses shorter than 50 ms are ignored completely
// RULE_20: a preselection switch in advanced config shows 0h for 200 ms
// RULE_21: at most one safe-mode output is high at any time
// RULE_22: level n permits modes 1 to n, level 5 adds mode 5; the code also refuses every selection while the current mode is above n
// RULE_23: all timings derive from one free-running tick counter
`timescale 1ns/1ps
`default_nettype none
`include "mode_selector_consts.vh"
module mode_selector #(
	parameter TICK_CYCLES = `TICK_NS / `CLK_NS
) (
	input wire sys_clk,
	input wire nrst,
	input wire clk_en,
	input wire [3:0] button_in,
	input wire [3:0] dip_switch,
	input wire tag_present,
	input wire [2:0] tag_level,
	input wire [4:0] safe_mode_fb,
	input wire mode_lock,
	input wire preselect_req,
	input wire [2:0] preselect_mode,
	input wire internal_fault,
	input wire [2:0] stored_mode_in,
	output reg [4:0] safe_mode_out,
	output reg [3:0] display_out,
	output reg [3:0] status_code,
	output reg device_error,
	output reg [2:0] stored_mode_out
);
	localparam [2:0] ST_INIT = 3'b001;
	localparam [2:0] ST_RUN = 3'b010;
	localparam [2:0] ST_ERR = 3'b100;
	localparam [2:0] P_IDLE = 3'b001;
	localparam [2:0] P_HOLD = 3'b010;
	localparam [2:0] P_WAIT = 3'b100;
	localparam integer FILTER_I = `MS_TICKS(`FILTER_MS);
	localparam integer LONG_I = `MS_TICKS(`LONG_MS);
	localparam integer LONG5_I = `MS_TICKS(`LONG5_MS);
	localparam integer SERVICE_I = `MS_TICKS(`SERVICE_MS);
	localparam integer MSG_I = `MS_TICKS(`MSG_MS);
	localparam integer FLASH_I = `MS_TICKS(`FLASH_MS);
	localparam integer STUCK_I = `MS_TICKS(`STUCK_MS);
	localparam [13:0] N_FILTER = FILTER_I[13:0];
	localparam [13:0] N_LONG = LONG_I[13:0];
	localparam [13:0] N_LONG5 = LONG5_I[13:0];
	localparam [13:0] N_SERVICE = SERVICE_I[13:0];
	localparam [13:0] N_MAX = 14'h3fff;
	localparam [7:0] N_MSG = MSG_I[7:0];
	localparam [7:0] N_FLASH = FLASH_I[7:0];
	localparam [4:0] N_STUCK = STUCK_I[4:0];

	wire [16:0] s;
	wire tick;
	input_sync #(.W(17)) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.din({safe_mode_fb, tag_level, tag_present, dip_switch, button_in}),
		.dout(s)
	);
	tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.clk_en(clk_en),
		.tick(tick)
	);
	wire [3:0] btn = s[3:0];
	wire [3:0] dip = s[7:4];
	wire tag = s[8];
	wire [2:0] lvl = s[11:9];
	wire [4:0] fb = s[16:12];

	reg [2:0] st_q;
	reg [2:0] ps_q;
	reg [2:0] mode_q;
	reg [3:0] dip_cfg_q;
	reg [2:0] init_cnt_q;
	reg tag_prev_q;
	reg [3:0] msg_q;
	reg msg_on_q;
	reg [7:0] msg_cnt_q;
	reg [7:0] blink_cnt_q;
	reg blink_q;
	reg [4:0] stuck_cnt_q;
	reg [3:0] press_btn_q;
	reg [13:0] press_cnt_q;
	reg tag_at_start_q;
	reg tag_lost_q;

	wire [1:0] beh = dip_cfg_q[`DIP_BEH_MSB:`DIP_BEH_LSB];
	wire adv = dip_cfg_q[`DIP_ADV_BIT];
	wire dip_ok = ~dip[`DIP_RSV_BIT]; // RULE_01
	wire one_btn = (btn != 4'h0) && ((btn & (btn - 4'h1)) == 4'h0);
	wire lvl_ok = (lvl != 3'h0) && (lvl <= `MODE_5);
	wire mode_ok = (mode_q != 3'h0) && (mode_q <= `MODE_5);
	wire stored_ok = (stored_mode_in != 3'h0) && (stored_mode_in <= `MODE_5);
	wire too_long = press_btn_q[0] ? (press_cnt_q > N_LONG5) : (press_cnt_q > N_LONG); // RULE_17
	wire [2:0] target = press_btn_q[0] ? ((press_cnt_q >= N_SERVICE) ? `MODE_5 : `MODE_1) :
		press_btn_q[1] ? 3'h2 : press_btn_q[2] ? 3'h3 : `MODE_4; // RULE_07

	// one decoded line per mode keeps the outputs one-hot by construction
	wire [4:0] mode_dec;
	genvar i;
	generate
		for (i = 0; i < 5; i = i + 1) begin : g_dec
			assign mode_dec[i] = (mode_q == i + 1); // RULE_21
		end
	endgenerate

	function [3:0] mode_code;
		input [2:0] m;
		begin
			if (m == `MODE_5)
				mode_code = `CODE_MODE5; // RULE_10
			else
				mode_code = `CODE_MODE1 + {2'h0, m[1:0] - 2'h1}; // RULE_10
		end
	endfunction

	task post;
		input [3:0] c;
		begin
			msg_q <= c;
			msg_on_q <= 1'b1;
			msg_cnt_q <= N_MSG;
		end
	endtask

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= ST_INIT;
			ps_q <= P_IDLE;
			mode_q <= `MODE_RST;
			dip_cfg_q <= 4'h0;
			init_cnt_q <= 3'h0;
			tag_prev_q <= 1'b0;
			msg_q <= `STATUS_RST;
			msg_on_q <= 1'b0;
			msg_cnt_q <= 8'h00;
			blink_cnt_q <= 8'h00;
			blink_q <= 1'b0;
			stuck_cnt_q <= 5'h00;
			press_btn_q <= 4'h0;
			press_cnt_q <= 14'h0000;
			tag_at_start_q <= 1'b0;
			tag_lost_q <= 1'b0;
		end else if (clk_en) begin
			if (tick) begin
				if (msg_cnt_q == 8'h01)
					msg_on_q <= 1'b0; // RULE_13
				if (msg_cnt_q != 8'h00)
					msg_cnt_q <= msg_cnt_q - 8'h01;
				if (blink_cnt_q == N_FLASH - 8'h01) begin
					blink_cnt_q <= 8'h00;
					blink_q <= ~blink_q;
				end else
					blink_cnt_q <= blink_cnt_q + 8'h01;
			end
			case (st_q)
			ST_INIT: begin
				// give the synchronisers time to settle before trusting the switches
				init_cnt_q <= init_cnt_q + 3'h1;
				if (init_cnt_q == 3'h7) begin
					dip_cfg_q <= dip;
					tag_prev_q <= tag;
					if (!dip_ok)
						st_q <= ST_ERR; // RULE_01
					else begin
						st_q <= ST_RUN;
						if (dip[`DIP_BEH_MSB:`DIP_BEH_LSB] == `BEH_STORE && stored_ok)
							mode_q <= stored_mode_in; // RULE_05
						else
							mode_q <= `MODE_1; // RULE_04
					end
				end
			end
			ST_RUN: begin
				tag_prev_q <= tag;
				// stuck output: feedback disagrees for a whole window
				if (fb != safe_mode_out) begin
					if (tick && stuck_cnt_q != N_STUCK)
						stuck_cnt_q <= stuck_cnt_q + 5'h01;
				end else
					stuck_cnt_q <= 5'h00;
				if (adv && preselect_req && preselect_mode != 3'h0 && preselect_mode <= `MODE_5) begin
					mode_q <= preselect_mode;
					post(`CODE_PRESEL); // RULE_20
				end
				if (tag && !tag_prev_q && lvl_ok) begin
					if (lvl == `MODE_5)
						post(`CODE_SVC_TAG); // RULE_11
					else
						post(`CODE_TAG1 + {1'b0, lvl - 3'h1}); // RULE_11
				end
				if (!tag && tag_prev_q) begin // RULE_02
					post(`CODE_TAG_OUT); // RULE_12
					if (beh == `BEH_FALLBACK)
						mode_q <= `MODE_1; // RULE_03
					else if (beh == `BEH_DEFAULT && mode_q == `MODE_5)
						mode_q <= `MODE_1; // RULE_03
					// retention and storage leave mode_q alone
				end
				case (ps_q)
				P_IDLE: begin
					if (btn != 4'h0) begin
						press_btn_q <= btn;
						press_cnt_q <= 14'h0000;
						tag_at_start_q <= tag;
						tag_lost_q <= 1'b0;
						// a short double press must stay silent, so misuse waits for the filter
						ps_q <= one_btn ? P_HOLD : P_WAIT;
					end
				end
				P_HOLD: begin
					if (tick && press_cnt_q != N_MAX)
						press_cnt_q <= press_cnt_q + 14'h0001;
					if (!tag && tag_at_start_q)
						tag_lost_q <= 1'b1;
					if ((btn & ~press_btn_q) != 4'h0) begin
						ps_q <= P_WAIT;
						if (press_cnt_q >= N_FILTER)
							post(`CODE_BAD_BTN); // RULE_18
					end else if (too_long) begin
						ps_q <= P_WAIT;
						post(`CODE_BAD_BTN); // RULE_17
					end else if (btn == 4'h0) begin
						ps_q <= P_IDLE;
						// short presses fall through with no effect
						if (press_cnt_q >= N_FILTER) begin // RULE_19
							if (tag_lost_q || (tag_at_start_q && !tag))
								post(`CODE_BAD_BTN); // RULE_18
							else if (adv && mode_lock)
								post(`CODE_NO_PERM); // RULE_15
							else if (!tag_at_start_q || !lvl_ok)
								post(`CODE_NO_PERM); // RULE_14
							else if (target > lvl || mode_q > lvl)
								post(`CODE_NO_PERM); // RULE_22
							else begin
								mode_q <= target; // RULE_07
								msg_on_q <= 1'b0;
								msg_cnt_q <= 8'h00;
							end
						end
					end
				end
				P_WAIT: begin
					if (tick && press_cnt_q != N_MAX)
						press_cnt_q <= press_cnt_q + 14'h0001;
					if (tick && press_cnt_q == N_FILTER - 14'h0001)
						post(`CODE_BAD_BTN); // RULE_18
					if (btn == 4'h0)
						ps_q <= P_IDLE;
				end
				default: ps_q <= P_IDLE;
				endcase
				if (dip != dip_cfg_q || internal_fault || !mode_ok || stuck_cnt_q == N_STUCK)
					st_q <= ST_ERR; // RULE_16
			end
			ST_ERR: st_q <= ST_ERR;
			default: st_q <= ST_ERR;
			endcase
		end
	end

	// outputs are registered copies; the error state forces every mode line low
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			safe_mode_out <= 5'h00;
			display_out <= 4'h0;
			status_code <= `STATUS_RST;
			device_error <= 1'b0;
			stored_mode_out <= `MODE_RST;
		end else if (clk_en) begin
			stored_mode_out <= mode_q;
			if (st_q == ST_RUN) begin
				safe_mode_out <= mode_dec; // RULE_21
				display_out <= mode_dec[4] ? {4{blink_q}} : mode_dec[3:0]; // RULE_06
				status_code <= msg_on_q ? msg_q : mode_code(mode_q); // RULE_13
				device_error <= 1'b0;
			end else if (st_q == ST_ERR) begin
				safe_mode_out <= 5'h00;
				display_out <= 4'h0;
				status_code <= `CODE_DEV_ERR; // RULE_12
				device_error <= 1'b1;
			end else begin
				safe_mode_out <= 5'h00;
				display_out <= 4'h0;
				status_code <= `STATUS_RST;
				device_error <= 1'b0;
			end
		end
	end
endmodule // mode_selector
`default_nettype wire

// File: testbench/safety_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module safety_ctl_model (
	input wire logic stuck,
	input wire logic [4:0] safe_mode_out,
	output logic [4:0] safe_mode_fb,
	output logic multi_err
);
	// readback pin; stuck models a shorted output
	assign safe_mode_fb = stuck ? 5'h00 : safe_mode_out;
	// all zeros is legal at power-up and switchover
	assign multi_err = (safe_mode_out & (safe_mode_out - 5'h01)) != 5'h00;
endmodule // safety_ctl_model
`default_nettype wire

// File: testbench/mode_selector_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "mode_selector_consts.vh"
module mode_selector_chk #(
	parameter TICK_CYCLES = `TICK_NS / `CLK_NS
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire logic [3:0] button_in,
	input wire logic [3:0] dip_switch,
	input wire logic tag_present,
	input wire logic internal_fault,
	input wire logic [4:0] safe_mode_out,
	input wire logic [3:0] display_out,
	input wire logic [3:0] status_code,
	input wire logic device_error
);
	logic [31:0] msg_q;
	logic [4:0] run_q;
	wire logic steady = status_code == `CODE_MODE5 || status_code[3:2] == 2'h2 || status_code == `CODE_DEV_ERR;
	// run_q masks sync and init latency after reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			msg_q <= 32'h0;
			run_q <= 5'h0;
		end else begin
			if (!run_q[4])
				run_q <= run_q + 5'h1;
			if (steady || $changed(status_code))
				msg_q <= 32'h0;
			else if (clk_en)
				msg_q <= msg_q + 32'h1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence tag_gone;
		$fell(tag_present) && run_q[4] && button_in == 4'h0 && !device_error;
	endsequence
	sequence back_to_one;
		##[4:10] (safe_mode_out == 5'h01 && status_code == `CODE_TAG_OUT);
	endsequence
	chk_one_hot: assert property ($onehot0(safe_mode_out))
		else $error("several mode outputs high");
	chk_err_quiet: assert property (device_error |-> !safe_mode_out && !display_out && status_code == `CODE_DEV_ERR)
		else $error("error state outputs wrong");
	chk_err_sticky: assert property (device_error |=> device_error)
		else $error("error state left");
	chk_fault_err: assert property (internal_fault && run_q[4] |-> ##[1:4] device_error)
		else $error("fault not reported");
	chk_disp_mode: assert property (safe_mode_out[3:0] != 4'h0 |-> display_out == safe_mode_out[3:0])
		else $error("display differs from mode");
	chk_disp_flash: assert property (safe_mode_out[4] |-> display_out == 4'hf || display_out == 4'h0)
		else $error("mode 5 display wrong");
	chk_code_mode: assert property (safe_mode_out != 5'h0 && status_code[3:2] == 2'h2 |-> safe_mode_out == 5'h1 << status_code[1:0])
		else $error("mode code differs from output");
	chk_msg_hold: assert property (msg_q <= 202 * TICK_CYCLES)
		else $error("message held too long");
	chk_fall_back: assert property (dip_switch[1:0] == `BEH_FALLBACK ##0 tag_gone |-> back_to_one)
		else $error("no fallback to mode 1");
	chk_reset_vals: assert property ($rose(nrst) |-> safe_mode_out == 5'h0 && status_code == `STATUS_RST)
		else $error("reset outputs wrong");
endmodule // mode_selector_chk
bind mode_selector mode_selector_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.sys_clk(sys_clk), .nrst(nrst),
	.clk_en(clk_en), .button_in(button_in), .dip_switch(dip_switch), .tag_present(tag_present),
	.internal_fault(internal_fault), .safe_mode_out(safe_mode_out), .display_out(display_out),
	.status_code(status_code), .device_error(device_error));
`default_nettype wire

// File: testbench/mode_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mode_selector_consts.vh"
module mode_selector_tb;
	localparam int TC = 2;
	logic sys_clk = 0, nrst = 0, tag_present = 0, mode_lock = 0, preselect_req = 0, internal_fault = 0, stuck = 0;
	logic clk_en = 1;
	logic [3:0] button_in = 4'h0, dip_switch = 4'h0, status_code, display_out, d;
	logic [2:0] tag_level = 3'h0, preselect_mode = 3'h0, stored_mode_in = 3'h0, stored_mode_out;
	logic [4:0] safe_mode_fb, safe_mode_out;
	logic device_error, multi_err;
	int err_total = 0, checks_done = 0, seed = 32'h7e37, i, n;
	always #2.5 sys_clk = ~sys_clk;
	mode_selector #(.TICK_CYCLES(TC)) DUT (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .button_in(button_in),
		.dip_switch(dip_switch), .tag_present(tag_present), .tag_level(tag_level), .safe_mode_fb(safe_mode_fb),
		.mode_lock(mode_lock), .preselect_req(preselect_req), .preselect_mode(preselect_mode),
		.internal_fault(internal_fault), .stored_mode_in(stored_mode_in), .safe_mode_out(safe_mode_out),
		.display_out(display_out), .status_code(status_code), .device_error(device_error),
		.stored_mode_out(stored_mode_out));
	safety_ctl_model ctl (.stuck(stuck), .safe_mode_out(safe_mode_out), .safe_mode_fb(safe_mode_fb),
		.multi_err(multi_err));
	function automatic logic [4:0] mbit(input int m);
		return 5'h1 << (m - 1);
	endfunction
	function automatic logic [3:0] mcode(input int m);
		return m == 5 ? `CODE_MODE5 : `CODE_MODE1 + 4'(m - 1);
	endfunction
	function automatic logic [3:0] tcode(input int l);
		return l == 5 ? `CODE_SVC_TAG : `CODE_TAG1 + 4'(l - 1);
	endfunction
	task automatic results();
		if (err_total == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge sys_clk);
	endtask
	task automatic cmp_mode(input logic [4:0] e);
		checks_done++;
		if ({multi_err, safe_mode_out} !== {1'b0, e}) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, safe_mode_out, e);
		end
	endtask
	task automatic cmp_code(input logic [3:0] e);
		checks_done++;
		if (status_code !== e) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, status_code, e);
		end
	endtask
	task automatic cmp_disp(input logic [3:0] e);
		checks_done++;
		if (display_out !== e) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, display_out, e);
		end
	endtask
	task automatic cmp_store(input logic [2:0] e);
		checks_done++;
		if (stored_mode_out !== e) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, stored_mode_out, e);
		end
	endtask
	// hold time in ticks, then room for sync and answer
	task automatic press(input logic [3:0] b, input int t);
		button_in = b;
		cyc(t * TC);
		button_in = 4'h0;
		cyc(12);
	endtask
	task automatic tag(input int l, input logic p);
		tag_level = 3'(l);
		tag_present = p;
		cyc(12);
	endtask
	task automatic rst(input logic [3:0] d, input logic [2:0] s);
		nrst = 0;
		dip_switch = d;
		stored_mode_in = s;
		tag_present = 0;
		cyc(10);
		nrst = 1;
		cyc(30);
	endtask
	initial begin
		rst(4'h0, 3'h0);
		cmp_mode(mbit(1));
		for (i = 1; i <= 5; i++) begin
			tag(i, 1);
			cmp_code(tcode(i));
			tag(i, 0);
			cmp_code(`CODE_TAG_OUT);
		end
		tag(3, 1);
		press(4'h2, 100);
		cmp_mode(mbit(2));
		cmp_code(mcode(2));
		cmp_store(3'h2);
		for (i = 0; i < 4; i++) begin
			n = $random(seed);
			press((4'h1 << n[1:0]) | n[11:8], 1 + n[7:2] % 40);
			cmp_mode(mbit(2));
			cmp_code(mcode(2));
		end
		press(4'h8, 100);
		cmp_code(`CODE_NO_PERM);
		press(4'h6, 100);
		cmp_code(`CODE_BAD_BTN);
		cyc(205 * TC);
		cmp_code(mcode(2));
		press(4'h2, 5010);
		cmp_code(`CODE_BAD_BTN);
		// tag leaves while button 3 is still held
		button_in = 4'h4;
		cyc(100 * TC);
		tag(3, 0);
		button_in = 4'h0;
		cyc(12);
		cmp_code(`CODE_BAD_BTN);
		cmp_mode(mbit(2));
		press(4'h2, 100);
		cmp_code(`CODE_NO_PERM);
		tag(5, 1);
		press(4'h1, 3100);
		cmp_mode(mbit(5));
		cmp_code(mcode(5));
		d = display_out;
		cmp_disp({4{d[0]}});
		// frozen clock enable must hold the flash phase
		clk_en = 0;
		cyc(`FLASH_MS * TC);
		cmp_disp(d);
		clk_en = 1;
		cyc(`FLASH_MS * TC);
		cmp_disp(~d);
		tag(5, 0);
		cmp_mode(mbit(1));
		dip_switch = 4'h1;
		cyc(12);
		cmp_code(`CODE_DEV_ERR);
		rst(4'h2, 3'h0);
		tag(4, 1);
		press(4'h8, 100);
		cmp_mode(mbit(4));
		tag(4, 0);
		cmp_mode(mbit(1));
		rst(4'h3, 3'h3);
		cmp_mode(mbit(3));
		cmp_store(3'h3);
		tag(3, 1);
		tag(3, 0);
		cmp_mode(mbit(3));
		internal_fault = 1;
		cyc(12);
		cmp_mode(5'h0);
		internal_fault = 0;
		rst(4'h5, 3'h0);
		preselect_mode = 3'h5;
		preselect_req = 1;
		cyc(1);
		preselect_req = 0;
		cyc(12);
		cmp_code(`CODE_PRESEL);
		cmp_mode(mbit(5));
		tag(5, 1);
		tag(5, 0);
		cmp_mode(mbit(5));
		tag(5, 1);
		mode_lock = 1;
		press(4'h2, 100);
		cmp_code(`CODE_NO_PERM);
		cmp_mode(mbit(5));
		mode_lock = 0;
		stuck = 1;
		cyc(30 * TC);
		cmp_code(`CODE_DEV_ERR);
		stuck = 0;
		rst(4'h8, 3'h0);
		cmp_code(`CODE_DEV_ERR);
		results();
	end
	initial begin
		#300000;
		err_total++;
		results();
	end
endmodule // mode_selector_tb
`default_nettype wire
